// ==== logic/ssms_top.sv ====
// Synchronous master/slave serial unit with APB register access
// Function
// RULE1 - Software programs baud divisor before reception
// RULE2 - Sync, enable, master select; receive enables clear
// RULE3 - Port enable on; clearing resets unit
// RULE4 - Master receive starts on single or continuous
// RULE5 - Receive flag on character; optional interrupt
// RULE6 - Software reads status before data
// RULE7 - Overrun cleared by continuous clear or disable
// RULE8 - Software keeps address detect cleared
// RULE9 - Master select clear means external clock slave
// RULE10 - Both receive enables clear means transmit
// RULE11 - Slave transmit same as master transmit
// RULE12 - Two writes: first shifts, second held
// RULE13 - After shift out, move held, set flag
// RULE14 - Transmit interrupt wakes; global enable vectors
// RULE15 - Software enables transmit then writes holding
// RULE16 - Ninth bit placed before low byte
// RULE17 - Slave receive always continuous; single ignored
// RULE18 - Slave receives in sleep, interrupt wakes
// RULE19 - Single: one character clocks; continuous until cleared
// RULE20 - Data changes leading, sampled trailing edge; transmit shifter changes data on the trailing edge instead
// RULE21 - Two-entry FIFO, third sets overrun, stops
// RULE22 - Slave releases clock pin, takes peer clock
// RULE23 - Disabled unit holds reset, drives no pins
`timescale 1ns/1ps
`include "ssms_defs.svh"
module ssms_top
  import ssms_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock pin
  input wire logic clock_pin_i,
  output logic clock_pin_o,
  output logic clock_pin_oe,
  // Data pin
  input wire logic data_pin_i,
  output logic data_pin_o,
  output logic data_pin_oe,
  // Core state
  input wire logic sleep_i,
  output logic wake_o,
  output logic isr_o
);
  logic [7:0] rxctl_r;
  logic [7:0] txctl_r;
  logic [7:0] baud_r;
  logic [3:0] intctl_r;
  logic [8:0] tx_hold_r;
  logic hold_full_r;
  logic [8:0] tx_shift_r;
  logic [8:0] rx_shift_r;
  logic [3:0] bit_cnt_r;
  logic [8:0] brg_cnt_r;
  logic ck_int_r;
  logic ck_sync;
  logic ck_prev_r;
  logic dt_sync;
  logic overrun_error_r;
  logic cont_q_r;
  ssms_shift_type state_r;
  logic fifo_full;
  logic fifo_ne;
  logic [8:0] fifo_data;
  logic fifo_push;
  logic fifo_pop;
  logic en;
  logic master;
  logic cont;
  logic rx_mode;
  logic [3:0] nbits;
  logic trail;
  logic brg_tick;
  logic wr;
  logic rd;
  logic rx_done;
  logic tx_done;
  logic txflag;
  logic rxflag;
  logic mapped;
  logic [31:0] rdata;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  ssms_sync2 u_ck (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din(clock_pin_i),
    .dout(ck_sync)
  );
  ssms_sync2 u_dt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din(data_pin_i),
    .dout(dt_sync)
  );

  assign en = rxctl_r[`SSMS_RC_EN] && txctl_r[`SSMS_TC_SYNC]; // RULE2 RULE3
  assign master = txctl_r[`SSMS_TC_MASTER]; // RULE9
  assign cont = rxctl_r[`SSMS_RC_CONT];
  // Slave ignores the single enable
  assign rx_mode = master ? (cont || rxctl_r[`SSMS_RC_SINGLE]) : cont; // RULE10 RULE17
  assign nbits = (rx_mode ? rxctl_r[`SSMS_RC_NINE] : txctl_r[`SSMS_TC_NINE]) ? 4'd9 : 4'd8;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign fifo_pop = rd && hit(paddr, `SSMS_OFF_RXDATA);

  // Baud tick: divisor+1 system cycles, doubled when high baud select is clear
  // Pin and synchroniser round trip needs a half period of four cycles or more
  assign brg_tick = brg_cnt_r == 9'd0;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      brg_cnt_r <= 9'd0;
    else if (!en || state_r == SSMS_IDLE || brg_tick)
      brg_cnt_r <= txctl_r[`SSMS_TC_HIGH_BAUD_SELECT] ? {1'b0, baud_r} : {baud_r, 1'b0} + 9'd1;
    else
      brg_cnt_r <= brg_cnt_r - 9'd1;
  end

  // Edge finder; clock idles low, rising is leading
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      ck_prev_r <= 1'b0;
    else
      ck_prev_r <= ck_sync;
  end
  assign trail = master ? (brg_tick && ck_int_r) : (!ck_sync && ck_prev_r); // RULE20 RULE22

  assign rx_done = state_r == SSMS_RX && trail && bit_cnt_r == nbits - 4'd1;
  assign tx_done = state_r == SSMS_TX && trail && bit_cnt_r == nbits - 4'd1;
  assign fifo_push = rx_done && !fifo_full;

  // Shift engine
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SSMS_IDLE;
      bit_cnt_r <= 4'd0;
      ck_int_r <= 1'b0;
      tx_shift_r <= 9'h000;
      rx_shift_r <= 9'h000;
      hold_full_r <= 1'b0;
    end else if (!en) begin // RULE23
      state_r <= SSMS_IDLE;
      bit_cnt_r <= 4'd0;
      ck_int_r <= 1'b0;
      rx_shift_r <= 9'h000;
      hold_full_r <= 1'b0;
    end else begin
      if (wr && hit(paddr, `SSMS_OFF_TXHOLD))
        hold_full_r <= 1'b1; // RULE12
      unique case (state_r)
        SSMS_IDLE: begin
          bit_cnt_r <= 4'd0;
          ck_int_r <= 1'b0;
          if (rx_mode && !overrun_error_r) begin
            state_r <= SSMS_RX; // RULE4
          end else if (!rx_mode && txctl_r[`SSMS_TC_TRANSMIT_ENABLE] && hold_full_r) begin
            tx_shift_r <= tx_hold_r; // RULE11 RULE12
            // A write in the load cycle stays held, not lost
            hold_full_r <= wr && hit(paddr, `SSMS_OFF_TXHOLD);
            state_r <= SSMS_TX;
          end
        end
        SSMS_RX: begin
          if (!rx_mode) begin
            state_r <= SSMS_IDLE; // RULE19
          end else begin
            if (master && brg_tick)
              ck_int_r <= ~ck_int_r;
            if (trail) begin
              rx_shift_r <= {dt_sync, rx_shift_r[8:1]}; // RULE20
              bit_cnt_r <= bit_cnt_r + 4'd1;
              if (rx_done) begin
                bit_cnt_r <= 4'd0;
                if (fifo_full || (master && !cont))
                  state_r <= SSMS_IDLE; // RULE21
              end
            end
          end
        end
        SSMS_TX: begin
          if (master && brg_tick)
            ck_int_r <= ~ck_int_r;
          if (trail) begin
            tx_shift_r <= {1'b0, tx_shift_r[8:1]};
            bit_cnt_r <= bit_cnt_r + 4'd1;
            if (tx_done) begin
              bit_cnt_r <= 4'd0;
              state_r <= SSMS_IDLE; // RULE13
            end
          end
        end
        default: state_r <= SSMS_IDLE;
      endcase
    end
  end

  // Ninth bit of a 9-bit character sits at the shifter top
  function automatic logic [8:0] align(input logic [8:0] s, input logic nine);
    return nine ? s : {1'b0, s[8:1]};
  endfunction

  ssms_rxfifo u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clr(!en),
    .push(fifo_push), // RULE21
    .wdata(align({dt_sync, rx_shift_r[8:1]}, rxctl_r[`SSMS_RC_NINE])),
    .full(fifo_full),
    .pop(fifo_pop),
    .rdata(fifo_data),
    .not_empty(fifo_ne)
  );

  // Falling continuous enable is what clears a continuous overrun
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      cont_q_r <= 1'b0;
    else
      cont_q_r <= cont;
  end

  // Overrun: set on a third character, cleared by continuous clear, disable, or a data read while continuous is clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      overrun_error_r <= 1'b0;
    else if (!en)
      overrun_error_r <= 1'b0; // RULE3 RULE7
    else if (rx_done && fifo_full)
      overrun_error_r <= 1'b1; // RULE21
    else if (cont_q_r && !cont)
      overrun_error_r <= 1'b0; // RULE7
    else if (!cont && fifo_pop)
      overrun_error_r <= 1'b0;
  end

  assign rxflag = fifo_ne; // RULE5
  assign txflag = !hold_full_r; // RULE13

  // Registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxctl_r <= `SSMS_RXCTL_RST;
      txctl_r <= `SSMS_TXCTL_RST;
      baud_r <= `SSMS_BAUD_RST;
      intctl_r <= `SSMS_INTCTL_RST;
      tx_hold_r <= 9'h000;
    end else begin
      if (wr && hit(paddr, `SSMS_OFF_RXCTL))
        rxctl_r <= {pwdata[7:3], 3'b000};
      else if (rx_done && master && !cont)
        rxctl_r[`SSMS_RC_SINGLE] <= 1'b0; // RULE19
      if (wr && hit(paddr, `SSMS_OFF_TXCTL))
        txctl_r <= {pwdata[7:4], 1'b0, pwdata[2], 1'b0, pwdata[0]};
      if (wr && hit(paddr, `SSMS_OFF_BAUD))
        baud_r <= pwdata[7:0];
      if (wr && hit(paddr, `SSMS_OFF_INTCTL))
        intctl_r <= pwdata[3:0];
      if (wr && hit(paddr, `SSMS_OFF_TXHOLD))
        tx_hold_r <= {txctl_r[`SSMS_TC_BIT9], pwdata[7:0]}; // RULE16
    end
  end

  always_comb begin
    mapped = 1'b1;
    rdata = 32'h0000_0000;
    unique case (paddr)
      `SSMS_OFF_RXCTL: rdata[7:0] = {rxctl_r[7:3], 1'b0, overrun_error_r, fifo_data[8]};
      `SSMS_OFF_RXDATA: rdata[7:0] = fifo_data[7:0];
      `SSMS_OFF_TXHOLD: rdata = 32'h0000_0000;
      `SSMS_OFF_TXCTL: rdata[7:0] = {txctl_r[7:2], state_r != SSMS_TX, txctl_r[0]};
      `SSMS_OFF_BAUD: rdata[7:0] = baud_r;
      `SSMS_OFF_INTCTL: rdata[7:0] = {isr_o, wake_o, txflag, rxflag, intctl_r};
      default: mapped = 1'b0;
    endcase
  end

  // Outputs registered; zero-wait APB
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rdata : 32'h0000_0000;
    end
  end

  logic irq_rx;
  logic irq_tx;
  assign irq_rx = rxflag && intctl_r[`SSMS_IC_RECEIVE_INT_ENABLE]; // RULE5 RULE18
  assign irq_tx = txflag && intctl_r[`SSMS_IC_TRANSMIT_INT_ENABLE] && intctl_r[`SSMS_IC_PERIPHERAL_INT_ENABLE]; // RULE14

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clock_pin_o <= 1'b0;
      clock_pin_oe <= 1'b0;
      data_pin_o <= 1'b0;
      data_pin_oe <= 1'b0;
      wake_o <= 1'b0;
      isr_o <= 1'b0;
    end else begin
      clock_pin_o <= ck_int_r;
      clock_pin_oe <= en && master; // RULE22 RULE23
      data_pin_o <= tx_shift_r[0];
      data_pin_oe <= en && !rx_mode; // RULE10
      wake_o <= sleep_i && (irq_rx || irq_tx); // RULE14 RULE18
      isr_o <= (irq_rx || irq_tx) && intctl_r[`SSMS_IC_GIE];
    end
  end

endmodule

// ==== logic/ssms_defs.svh ====
// Register offsets, field positions and reset values of the synchronous serial unit
`ifndef SSMS_DEFS_SVH
`define SSMS_DEFS_SVH
`define SSMS_OFF_RXCTL 12'h000
`define SSMS_OFF_RXDATA 12'h004
`define SSMS_OFF_TXHOLD 12'h008
`define SSMS_OFF_TXCTL 12'h00c
`define SSMS_OFF_BAUD 12'h010
`define SSMS_OFF_INTCTL 12'h014
// Receive control bits
`define SSMS_RC_EN 7
`define SSMS_RC_NINE 6
`define SSMS_RC_SINGLE 5
`define SSMS_RC_CONT 4
`define SSMS_RC_ADDR 3
`define SSMS_RC_FRAMING_ERROR 2
`define SSMS_RC_OVERRUN_ERROR 1
`define SSMS_RC_BIT9 0
// Transmit control bits
`define SSMS_TC_MASTER 7
`define SSMS_TC_NINE 6
`define SSMS_TC_TRANSMIT_ENABLE 5
`define SSMS_TC_SYNC 4
`define SSMS_TC_HIGH_BAUD_SELECT 2
`define SSMS_TC_EMPTY 1
`define SSMS_TC_BIT9 0
// Interrupt control bits
`define SSMS_IC_GIE 0
`define SSMS_IC_PERIPHERAL_INT_ENABLE 1
`define SSMS_IC_RECEIVE_INT_ENABLE 2
`define SSMS_IC_TRANSMIT_INT_ENABLE 3
`define SSMS_IC_RXF 4
`define SSMS_IC_TXF 5
`define SSMS_IC_WAKE 6
`define SSMS_IC_ISR 7
`define SSMS_RXCTL_RST 8'h00
`define SSMS_TXCTL_RST 8'h02
`define SSMS_BAUD_RST 8'h00
`define SSMS_INTCTL_RST 4'h0
`endif

// ==== logic/ssms_pkg.sv ====
// Types of the synchronous serial unit
package ssms_pkg;
  typedef enum logic [1:0] {
    SSMS_IDLE,
    SSMS_TX,
    SSMS_RX
  } ssms_shift_type;
endpackage

// ==== logic/ssms_sync2.sv ====
// Two-flop synchroniser for a pin level
`timescale 1ns/1ps
module ssms_sync2 (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Level
  input wire logic din,
  output logic dout
);
  logic meta_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule

// ==== logic/ssms_rxfifo.sv ====
// Two-entry receive FIFO of nine-bit characters
`timescale 1ns/1ps
module ssms_rxfifo (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clr,
  // Write side
  input wire logic push,
  input wire logic [8:0] wdata,
  output logic full,
  // Read side
  input wire logic pop,
  output logic [8:0] rdata,
  output logic not_empty
);
  logic [8:0] mem_r [0:1];
  logic [1:0] cnt_r;
  logic rd_r;
  logic wr_r;
  assign full = cnt_r == 2'd2;
  assign not_empty = cnt_r != 2'd0;
  // Empty reads give zero, never the unreset storage
  assign rdata = not_empty ? mem_r[rd_r] : 9'h000;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 2'd0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else if (clr) begin
      cnt_r <= 2'd0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else begin
      if (push && !full)
        wr_r <= ~wr_r;
      if (pop && not_empty)
        rd_r <= ~rd_r;
      cnt_r <= cnt_r + {1'b0, push && !full} - {1'b0, pop && not_empty};
    end
  end
  // Storage needs no reset; count guards the contents
  always_ff @(posedge clk_sys) begin
    if (push && !full)
      mem_r[wr_r] <= wdata;
  end
endmodule

// ==== dv/ssms_top_asserts.sv ====
// Port checker for the synchronous serial unit
`timescale 1ns/1ps
module ssms_top_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and core
  input wire logic clock_pin_o,
  input wire logic clock_pin_oe,
  input wire logic data_pin_oe,
  input wire logic sleep_i,
  input wire logic wake_o,
  input wire logic isr_o
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic en_r, cont_r, mst_r, sync_r, gie_r;
  wire wr = psel && penable && pwrite && pready;
  wire mact = en_r && mst_r && sync_r;
  // Shadow of the control bits that steer the pins and isr_o
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {en_r, cont_r, mst_r, sync_r, gie_r} <= 5'h00;
    end else if (wr && paddr == 12'h000) begin
      {en_r, cont_r} <= {pwdata[7], pwdata[4]};
    end else if (wr && paddr == 12'h00c) begin
      {mst_r, sync_r} <= {pwdata[7], pwdata[4]};
    end else if (wr && paddr == 12'h014) begin
      gie_r <= pwdata[0];
    end
  end
  AST_ZERO_WAIT: assert property (psel && penable |-> pready)
    else $error("access cycle without pready");
  AST_READY_FIRST: assert property (pready |-> penable && $past(psel) && !$past(penable))
    else $error("pready outside first access cycle");
  AST_UNMAPPED: assert property (pready |-> pslverr == (paddr > 12'h014 || paddr[1:0] != 2'b00))
    else $error("pslverr does not match map");
  AST_RDATA_ZERO: assert property (!pready || pwrite |-> prdata == 32'h0)
    else $error("read data outside a read");
  AST_SLAVE_NO_CLK: assert property (!mst_r && !$past(mst_r) |-> !clock_pin_oe)
    else $error("slave drives clock pin");
  AST_MASTER_CLK: assert property (mact && $past(mact) |-> clock_pin_oe)
    else $error("master does not drive clock pin");
  AST_OFF_NO_DRIVE: assert property (!en_r && !$past(en_r) |-> !clock_pin_oe && !data_pin_oe)
    else $error("disabled unit drives a pin");
  AST_RX_NO_DATA: assert property (cont_r && $past(cont_r) |-> !data_pin_oe)
    else $error("receiver drives data pin");
  AST_CLK_LOW: assert property ($rose(clock_pin_oe) |-> !clock_pin_o)
    else $error("clock does not start low");
  AST_WAKE_SLEEP: assert property (wake_o |-> $past(sleep_i))
    else $error("wake without sleep");
  AST_ISR_GLOBAL: assert property (isr_o |-> $past(gie_r))
    else $error("vector without global enable");
  COV_ERR: cover property (pready && pslverr);
  COV_WAKE: cover property (wake_o);
  COV_ISR: cover property (isr_o);
endmodule
bind ssms_top ssms_top_asserts u_ssms_top_asserts (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .clock_pin_o(clock_pin_o), .clock_pin_oe(clock_pin_oe), .data_pin_oe(data_pin_oe),
  .sleep_i(sleep_i), .wake_o(wake_o), .isr_o(isr_o)
);

// ==== dv/ssms_peer.sv ====
// Behavioural far-side peer of the serial link
`timescale 1ns/1ps
module ssms_peer (
  // System clock paces the peer clock
  input wire logic clk_sys,
  // Line
  input wire logic clk_line,
  input wire logic dat_line,
  // Peer drive
  output logic clk_drv,
  output logic dat_drv
);
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  int rises;
  initial begin
    clk_drv = 1'b0;
    dat_drv = 1'b0;
    tx_sh = 8'h00;
    rx_sh = 8'h00;
    rises = 0;
  end
  // Spent bits refill inverted, so stale data never looks valid
  always @(posedge clk_line) begin
    dat_drv <= tx_sh[0];
    tx_sh <= {~tx_sh[0], tx_sh[7:1]};
    rises <= rises + 1;
  end
  always @(negedge clk_line) begin
    rx_sh <= {dat_line, rx_sh[7:1]};
  end
  // One clock per bit, 200 ns period, low between frames
  task automatic run(input int bits);
    repeat (bits) begin
      repeat (4) @(posedge clk_sys);
      clk_drv <= 1'b1;
      repeat (4) @(posedge clk_sys);
      clk_drv <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
  endtask
endmodule

// ==== dv/ssms_top_tb.sv ====
// Register-level bench of the synchronous serial unit
`timescale 1ns/1ps
module ssms_top_tb;
  logic clk_sys, rst_n, psel, penable, pwrite, sleep_i, last_err;
  logic pready, pslverr, clock_pin_o, clock_pin_oe, data_pin_o, data_pin_oe, wake_o, isr_o;
  logic clk_drv, dat_drv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  int errors, tests_run;
  // The unit sets the line while its enable is high, the peer otherwise
  wire clk_line = clock_pin_oe ? clock_pin_o : clk_drv;
  wire dat_line = data_pin_oe ? data_pin_o : dat_drv;
  ssms_top u_ssms_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_pin_i(clk_line), .clock_pin_o(clock_pin_o), .clock_pin_oe(clock_pin_oe),
    .data_pin_i(dat_line), .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe),
    .sleep_i(sleep_i), .wake_o(wake_o), .isr_o(isr_o)
  );
  ssms_peer u_ssms_peer (.clk_sys(clk_sys), .clk_line(clk_line), .dat_line(dat_line),
    .clk_drv(clk_drv), .dat_drv(dat_drv));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic check(input string s, input logic [31:0] seen, input logic [31:0] e);
    tests_run++;
    if (seen !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_v = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      errors++;
      results();
    end else begin
      @(posedge clk_sys);
    end
  endtask
  task automatic rdchk(input string s, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(s, rd_v, e);
  endtask
  task automatic poll(input logic [11:0] a, input int b);
    for (int n = 0; n < 300; n++) begin
      apb(1'b0, a, 32'h0);
      if (rd_v[b] === 1'b1) return;
    end
    errors++;
    results();
  endtask
  initial begin
    errors = 0;
    tests_run = 0;
    {rst_n, psel, penable, pwrite, sleep_i} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rdchk("txctl", 12'h00c, 32'h02);
    rdchk("rxctl", 12'h000, 32'h00);
    rdchk("unmapped", 12'h020, 32'h00);
    check("slverr", last_err, 32'h1);
    $display("test map done");
    u_ssms_peer.tx_sh = 8'h5a;
    u_ssms_peer.rises = 0;
    apb(1'b1, 12'h010, 32'h03);
    apb(1'b1, 12'h00c, 32'h94);
    apb(1'b1, 12'h000, 32'h80);
    apb(1'b1, 12'h000, 32'ha0);
    poll(12'h014, 4);
    check("clocks", u_ssms_peer.rises, 32'h8);
    rdchk("single", 12'h000, 32'h80);
    rdchk("rxdata", 12'h004, 32'h5a);
    $display("test master receive done");
    apb(1'b1, 12'h00c, 32'h10);
    apb(1'b1, 12'h014, 32'h06);
    apb(1'b1, 12'h000, 32'h90);
    sleep_i <= 1'b1;
    for (int i = 1; i <= 3; i++) begin
      u_ssms_peer.tx_sh = 8'(8'h11 * i);
      u_ssms_peer.run(8);
      if (i == 1) poll(12'h014, 4);
      if (i == 1) rdchk("wake", 12'h014, 32'h76);
    end
    poll(12'h000, 1);
    rdchk("overrun", 12'h000, 32'h92);
    rdchk("rx1", 12'h004, 32'h11);
    rdchk("rx2", 12'h004, 32'h22);
    apb(1'b1, 12'h000, 32'h80);
    rdchk("ovr clear", 12'h000, 32'h80);
    $display("test slave receive done");
    apb(1'b1, 12'h00c, 32'h30);
    apb(1'b1, 12'h014, 32'h0b);
    apb(1'b1, 12'h008, 32'ha5);
    apb(1'b1, 12'h008, 32'h3c);
    rdchk("txf held", 12'h014, 32'h0b);
    u_ssms_peer.run(8);
    poll(12'h014, 5);
    check("tx1", u_ssms_peer.rx_sh, 32'ha5);
    rdchk("txf wake", 12'h014, 32'heb);
    u_ssms_peer.run(8);
    check("tx2", u_ssms_peer.rx_sh, 32'h3c);
    apb(1'b1, 12'h000, 32'h00);
    @(negedge clk_sys);
    check("pins off", {clock_pin_oe, data_pin_oe}, 32'h0);
    $display("test slave transmit done");
    results();
  end
endmodule
